// ==== design/rio_pkg.sv ====
// Purpose: Shared constants for the remote I/O signal assignment block
// Assumes: 8-bit signal codes, one function bit per code
// Notes: Register offsets are word indices; the Avalon-MM byte address is four times the index
package rio_pkg;

    localparam int CODE_W = 8;
    localparam int NUM_FN = 256;
    localparam int NUM_RSLOT = 16;
    localparam int NUM_DIN = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;

    // Word indices inside the register window
    localparam logic [5:0] IDX_RIN_SEL = 6'h00;
    localparam logic [5:0] IDX_ROUT_SEL = 6'h10;
    localparam logic [5:0] IDX_DIN_SEL = 6'h20;
    localparam logic [5:0] IDX_RIN_STAT = 6'h30;
    localparam logic [5:0] IDX_ROUT_STAT = 6'h31;
    localparam logic [5:0] IDX_PERMIT_STAT = 6'h32;

    localparam logic [CODE_W-1:0] FWD_LIMIT_CODE = 8'h1C;
    localparam logic [CODE_W-1:0] REV_LIMIT_CODE = 8'h1D;
    localparam logic [CODE_W-1:0] ZERO_PHASE_CODE = 8'h9B;

    // Remote output slot selections after initialisation, slot 15 first
    localparam logic [NUM_RSLOT-1:0][CODE_W-1:0] ROUT_INIT = {
        8'h8C, 8'h8A, 8'h86, 8'h00, 8'hA2, 8'hA1, 8'hA0, 8'h88,
        8'h81, 8'h87, 8'hCC, 8'h90, 8'h00, ZERO_PHASE_CODE,
        REV_LIMIT_CODE, FWD_LIMIT_CODE};

    // Direct terminal selections after initialisation, terminal 5 first
    localparam logic [NUM_DIN-1:0][CODE_W-1:0] DIN_INIT = {
        8'h1D, 8'h1C, 8'h68, 8'h0C, 8'h01, 8'h1E};

endpackage

// ==== design/rio_fn_merge.sv ====
// Purpose: Merge several selectable input sources onto a function vector
// Assumes: Code 0 means unassigned and never drives a function
// Notes: Combinational; one loop iteration per function code 1 to 255, code 0 tied OFF
`timescale 1ns/1ns
`default_nettype none
module rio_fn_merge #(
    parameter int NSRC = 16
) (
    // Sources
    input wire logic [NSRC-1:0][rio_pkg::CODE_W-1:0] i_sel,
    input wire logic [NSRC-1:0] i_level,
    // Results
    output logic [rio_pkg::NUM_FN-1:0] o_active,
    output logic [rio_pkg::NUM_FN-1:0] o_bound
);

    assign o_active[0] = 1'b0;
    assign o_bound[0] = 1'b0;

    genvar f;
    generate
        for (f = 1; f < rio_pkg::NUM_FN; f = f + 1)
        begin : g_fn
            always_comb
            begin
                o_active[f] = 1'b0;
                o_bound[f] = 1'b0;
                for (int s = 0; s < NSRC; s = s + 1)
                begin
                    if (i_sel[s] == f[rio_pkg::CODE_W-1:0])
                    begin
                        o_bound[f] = 1'b1;
                        o_active[f] = o_active[f] | i_level[s];
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== design/rio_assign.sv ====
// Purpose: Remote I/O slot assignment between the fieldbus and internal functions
// Assumes: Fieldbus process-data logic runs on I_SYS_CLK; terminals are async pins
// Notes: Avalon-MM slave answers every request after one wait cycle
//
// What this block does
// - Remote slots travel over the fieldbus ports, apart from connector terminals.
// - Sixteen remote input slots, 0 to 15, each bindable to any input function.
// - Each input slot has its own select code, zero after initialisation.
// - Any function but the interlock, bound to several sources, is active when any source is.
// - Unbound operation-permit interlock is held permanently ON.
// - Interlock bound on terminal and slot is ON only when both are ON.
// - Sixteen remote output slots, each driven by its selected status function.
// - Output slots 0, 1, 2 default to codes 28, 29 and 155.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rio_assign #(
    parameter logic [rio_pkg::CODE_W-1:0] INTERLOCK_CODE = 8'h10
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // Avalon-MM register slave
    input wire logic [rio_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [rio_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [rio_pkg::DATA_W-1:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Fieldbus process data
    input wire logic [rio_pkg::NUM_RSLOT-1:0] I_RIN_WORD,
    output logic [rio_pkg::NUM_RSLOT-1:0] O_ROUT_WORD,
    // Connector input terminals
    input wire logic [rio_pkg::NUM_DIN-1:0] I_DIN_PIN,
    // Driver core
    input wire logic [rio_pkg::NUM_FN-1:0] I_STATUS_FN,
    output logic [rio_pkg::NUM_FN-1:0] O_INPUT_FN
);

    localparam int NR = rio_pkg::NUM_RSLOT;
    localparam int ND = rio_pkg::NUM_DIN;
    localparam int CW = rio_pkg::CODE_W;

    logic [NR-1:0][CW-1:0] rin_sel_q;
    logic [NR-1:0][CW-1:0] rin_sel_d;
    logic [NR-1:0][CW-1:0] rout_sel_q;
    logic [NR-1:0][CW-1:0] rout_sel_d;
    logic [ND-1:0][CW-1:0] din_sel_q;
    logic [ND-1:0][CW-1:0] din_sel_d;
    logic ack_q;
    logic ack_d;
    logic [rio_pkg::DATA_W-1:0] rdata_q;
    logic [rio_pkg::DATA_W-1:0] rdata_d;
    logic [ND-1:0] din_meta_q;
    logic [ND-1:0] din_sync_q;
    logic [NR-1:0] rout_q;
    logic [NR-1:0] rout_d;
    logic [rio_pkg::NUM_FN-1:0] fn_q;
    logic [rio_pkg::NUM_FN-1:0] fn_d;
    logic [rio_pkg::NUM_FN-1:0] rem_active;
    logic [rio_pkg::NUM_FN-1:0] rem_bound;
    logic [rio_pkg::NUM_FN-1:0] dir_active;
    logic [rio_pkg::NUM_FN-1:0] dir_bound;
    logic permit_now;
    logic req;
    logic take;
    logic [5:0] widx;

    assign req = I_AVS_READ | I_AVS_WRITE;
    assign take = req & ack_q;
    assign widx = I_AVS_ADDRESS[rio_pkg::ADDR_W-1:2];
    assign O_AVS_WAITREQUEST = req & ~ack_q;
    assign O_AVS_READDATA = rdata_q;
    assign O_ROUT_WORD = rout_q;
    assign O_INPUT_FN = fn_q;

    // Bus handshake: the first cycle of a request loads read data, the second ends it
    always_comb
    begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q;
        if (req && !ack_q)
        begin
            rdata_d = '0;
            if (widx < rio_pkg::IDX_RIN_SEL + 6'(NR))
            begin
                rdata_d[CW-1:0] = rin_sel_q[4'(widx - rio_pkg::IDX_RIN_SEL)];
            end
            else if (widx >= rio_pkg::IDX_ROUT_SEL && widx < rio_pkg::IDX_ROUT_SEL + 6'(NR))
            begin
                rdata_d[CW-1:0] = rout_sel_q[4'(widx - rio_pkg::IDX_ROUT_SEL)];
            end
            else if (widx >= rio_pkg::IDX_DIN_SEL && widx < rio_pkg::IDX_DIN_SEL + 6'(ND))
            begin
                rdata_d[CW-1:0] = din_sel_q[3'(widx - rio_pkg::IDX_DIN_SEL)];
            end
            else if (widx == rio_pkg::IDX_RIN_STAT)
            begin
                rdata_d[NR-1:0] = I_RIN_WORD;
            end
            else if (widx == rio_pkg::IDX_ROUT_STAT)
            begin
                rdata_d[NR-1:0] = rout_q;
            end
            else if (widx == rio_pkg::IDX_PERMIT_STAT)
            begin
                rdata_d[0] = fn_q[INTERLOCK_CODE];
            end
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Selection registers, written on the accepting edge through byte lane 0
    always_comb
    begin
        rin_sel_d = rin_sel_q;
        rout_sel_d = rout_sel_q;
        din_sel_d = din_sel_q;
        if (take && I_AVS_WRITE && I_AVS_BYTEENABLE[0])
        begin
            if (widx < rio_pkg::IDX_RIN_SEL + 6'(NR))
            begin
                rin_sel_d[4'(widx - rio_pkg::IDX_RIN_SEL)] = I_AVS_WRITEDATA[CW-1:0];
            end
            else if (widx >= rio_pkg::IDX_ROUT_SEL && widx < rio_pkg::IDX_ROUT_SEL + 6'(NR))
            begin
                rout_sel_d[4'(widx - rio_pkg::IDX_ROUT_SEL)] = I_AVS_WRITEDATA[CW-1:0];
            end
            else if (widx >= rio_pkg::IDX_DIN_SEL && widx < rio_pkg::IDX_DIN_SEL + 6'(ND))
            begin
                din_sel_d[3'(widx - rio_pkg::IDX_DIN_SEL)] = I_AVS_WRITEDATA[CW-1:0];
            end
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            rin_sel_q <= '0;
            rout_sel_q <= rio_pkg::ROUT_INIT;
            din_sel_q <= rio_pkg::DIN_INIT;
        end
        else
        begin
            rin_sel_q <= rin_sel_d;
            rout_sel_q <= rout_sel_d;
            din_sel_q <= din_sel_d;
        end
    end

    // Connector terminals are asynchronous
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            din_meta_q <= '0;
            din_sync_q <= '0;
        end
        else
        begin
            din_meta_q <= I_DIN_PIN;
            din_sync_q <= din_meta_q;
        end
    end

    rio_fn_merge #(
        .NSRC(NR)
    ) u_remote_merge (
        .i_sel(rin_sel_q),
        .i_level(I_RIN_WORD),
        .o_active(rem_active),
        .o_bound(rem_bound)
    );

    rio_fn_merge #(
        .NSRC(ND)
    ) u_direct_merge (
        .i_sel(din_sel_q),
        .i_level(din_sync_q),
        .o_active(dir_active),
        .o_bound(dir_bound)
    );

    // Interlock: free when unbound, AND of both kinds when bound on both
    always_comb
    begin
        if (rem_bound[INTERLOCK_CODE] && dir_bound[INTERLOCK_CODE])
        begin
            permit_now = rem_active[INTERLOCK_CODE] & dir_active[INTERLOCK_CODE];
        end
        else if (rem_bound[INTERLOCK_CODE] || dir_bound[INTERLOCK_CODE])
        begin
            permit_now = rem_active[INTERLOCK_CODE] | dir_active[INTERLOCK_CODE];
        end
        else
        begin
            permit_now = 1'b1;
        end
    end

    always_comb
    begin
        fn_d = rem_active | dir_active;
        fn_d[INTERLOCK_CODE] = permit_now;
    end

    // Remote outputs pick their status bit; code 0 stays OFF
    genvar k;
    generate
        for (k = 0; k < NR; k = k + 1)
        begin : g_rout
            always_comb
            begin
                if (rout_sel_q[k] == rio_pkg::CODE_NONE)
                begin
                    rout_d[k] = 1'b0;
                end
                else
                begin
                    rout_d[k] = I_STATUS_FN[rout_sel_q[k]];
                end
            end
        end
    endgenerate

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            rout_q <= '0;
            fn_q <= '0;
        end
        else
        begin
            rout_q <= rout_d;
            fn_q <= fn_d;
        end
    end

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    chk_rin_init_zero: assert property (disable iff (1'b0) I_RST |=> rin_sel_q == '0)
        else $error("remote input selections not zero after reset");

    chk_rout_init_codes: assert property (disable iff (1'b0)
        I_RST |=> rout_sel_q[0] == rio_pkg::FWD_LIMIT_CODE
            && rout_sel_q[1] == rio_pkg::REV_LIMIT_CODE
            && rout_sel_q[2] == rio_pkg::ZERO_PHASE_CODE)
        else $error("output slot defaults wrong after reset");

    chk_rout_follow: assert property (
        (rout_sel_q[0] != rio_pkg::CODE_NONE) ##1 $stable(rout_sel_q[0])
            |-> O_ROUT_WORD[0] == $past(I_STATUS_FN[rout_sel_q[0]]))
        else $error("output slot 0 does not follow its status bit");

    chk_rout_unassigned: assert property (
        (rout_sel_q[3] == rio_pkg::CODE_NONE) [*2] |-> !O_ROUT_WORD[3])
        else $error("unassigned output slot driven ON");

    chk_code0_quiet: assert property (!O_INPUT_FN[0])
        else $error("code 0 drove an input function");

    chk_permit_free: assert property (
        !rem_bound[INTERLOCK_CODE] && !dir_bound[INTERLOCK_CODE]
            |=> O_INPUT_FN[INTERLOCK_CODE])
        else $error("unbound interlock not ON");

    chk_permit_both: assert property (
        rem_bound[INTERLOCK_CODE] && dir_bound[INTERLOCK_CODE]
            |=> O_INPUT_FN[INTERLOCK_CODE]
                == ($past(rem_active[INTERLOCK_CODE]) && $past(dir_active[INTERLOCK_CODE])))
        else $error("interlock bound on both sources is not their AND");

    chk_slot_or: assert property (
        rin_sel_q[0] != rio_pkg::CODE_NONE && rin_sel_q[0] != INTERLOCK_CODE
            && I_RIN_WORD[0] |=> O_INPUT_FN[$past(rin_sel_q[0])])
        else $error("active remote slot did not raise its function");

    chk_bus_one_wait: assert property (
        req && O_AVS_WAITREQUEST ##1 req |-> !O_AVS_WAITREQUEST)
        else $error("request held longer than one wait cycle");

    chk_write_lands: assert property (
        take && I_AVS_WRITE && I_AVS_BYTEENABLE[0] && widx == rio_pkg::IDX_RIN_SEL
            |=> rin_sel_q[0] == $past(I_AVS_WRITEDATA[CW-1:0]))
        else $error("remote input selection write lost");

    cov_write_taken: cover property (take && I_AVS_WRITE);
    cov_read_taken: cover property (take && I_AVS_READ);
    cov_permit_and_off: cover property (rem_bound[INTERLOCK_CODE]
        && dir_bound[INTERLOCK_CODE] ##1 !O_INPUT_FN[INTERLOCK_CODE]);
    cov_rout_on: cover property (O_ROUT_WORD[0]);

endmodule
`default_nettype wire

// ==== sim/rio_fb_master.sv ====
// Purpose: Fieldbus master model feeding remote input slot levels
// Assumes: Process data is updated on the driver clock
// Notes: Slow mode delivers each new word one cycle later
`timescale 1ns/1ns
`default_nettype none
module rio_fb_master (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_slow,
    // Process data
    input wire logic [15:0] i_tx,
    output logic [15:0] o_rin
);
    logic [15:0] hold_q;

    always_ff @(posedge i_clk)
    begin
        hold_q <= i_tx;
        o_rin <= i_slow ? hold_q : i_tx;
    end
endmodule
`default_nettype wire

// ==== sim/rio_assign_tb.sv ====
// Purpose: Self-checking bench for rio_assign
// Assumes: Default interlock code; the bus master waits for waitrequest low
// Notes: A watcher process compares queued expectations at the rising edge
`timescale 1ns/1ns
`default_nettype none
module rio_assign_tb;
    typedef struct {logic [1:0] kind; logic [7:0] idx; logic [31:0] val;} rio_chk_t;
    localparam logic [7:0] IL = 8'h10;
    logic clk = 0;
    logic rst = 1;
    logic rd = 0;
    logic we = 0;
    logic fs = 0;
    logic slow = 0;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0;
    logic [3:0] be = 0;
    logic [15:0] tx = 0;
    logic [5:0] din = 0;
    logic [255:0] st = 0;
    logic [31:0] rdata;
    logic wq;
    logic [15:0] rin;
    logic [15:0] rout;
    logic [255:0] fn;
    logic [7:0] code [16];
    logic [15:0] e;
    logic [31:0] v;
    logic [15:0] pat [5] = '{16'h8000, 16'h0001, 16'h8001, 16'h0080, 16'h0000};
    rio_chk_t c;
    rio_chk_t q[$];
    int err_count = 0;
    int total_checks = 0;

    rio_fb_master u_rio_fb_master (.i_clk(clk), .i_slow(slow), .i_tx(tx), .o_rin(rin));
    rio_assign #(.INTERLOCK_CODE(IL)) u_rio_assign (
        .I_SYS_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(we), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wq), .I_RIN_WORD(rin),
        .O_ROUT_WORD(rout), .I_DIN_PIN(din), .I_STATUS_FN(st), .O_INPUT_FN(fn));

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge clk);
        rd <= !w;
        we <= w;
        addr <= a;
        wd <= d;
        be <= b;
        // Request stands until an edge sees waitrequest low; only the watchdog ends a hang
        @(posedge clk);
        while (wq !== 1'b0)
            @(posedge clk);
        rd <= 0;
        we <= 0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        q.push_back('{2'd0, a, x});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hF);
    endtask

    // Lets the slot levels settle before one function bit is compared
    task automatic fchk(input logic [7:0] f, input logic x);
        repeat (5) @(posedge clk);
        q.push_back('{2'd1, f, {31'h0, x}});
        fs <= 1;
        @(posedge clk);
        fs <= 0;
    endtask

    // Compares the remote output word directly at its port
    task automatic ochk(input logic [15:0] x);
        q.push_back('{2'd2, 8'h00, {16'h0, x}});
        fs <= 1;
        @(posedge clk);
        fs <= 0;
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk)
    begin
        if ((rd && wq === 1'b0) || fs)
        begin
            c = q.pop_front();
            if (c.kind == 2'd1)
                v = {31'h0, fn[c.idx]};
            else if (c.kind == 2'd2)
                v = {16'h0, rout};
            else
                v = rdata;
            total_checks++;
            if (v !== c.val)
            begin
                err_count++;
                $display("[ERR] %s %h exp %h got %h",
                         c.kind == 2'd1 ? "fn" : (c.kind == 2'd2 ? "rout" : "rdata"),
                         c.idx, c.val, v);
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(20038));
        repeat (12) @(posedge clk);
        rst <= 0;
        for (int k = 0; k < 16; k++)
            rchk(8'(4 * k), 32'h0);
        rchk(8'h40, 32'h1C);
        rchk(8'h44, 32'h1D);
        rchk(8'h48, 32'h9B);
        rchk(8'h94, 32'h1D);
        rchk(8'hC8, 32'h1);
        fchk(IL, 1'b1);
        for (int k = 0; k < 16; k++)
        begin
            code[k] = (k == 3) ? 8'h00 : 8'($urandom_range(1, 255));
            wr(8'(8'h40 + 4 * k), code[k]);
        end
        for (int r = 0; r < 2; r++)
        begin
            @(posedge clk);
            st <= r ? '1 : {8{$urandom()}};
            repeat (3) @(posedge clk);
            for (int k = 0; k < 16; k++)
                e[k] = code[k] != 8'h00 && st[code[k]];
            ochk(e);
            rchk(8'hC4, {16'h0, e});
        end
        wr(8'hFC, 8'h55);
        rchk(8'hFC, 32'h0);
        bus(1'b1, 8'h08, 32'h7, 4'hE);
        rchk(8'h08, 32'h0);
        for (int k = 0; k < 16; k++)
            wr(8'(4 * k), 8'(32 + k));
        e = 16'($urandom());
        tx <= e;
        slow <= 1;
        for (int k = 0; k < 16; k++)
            fchk(8'(32 + k), e[k]);
        rchk(8'hC0, {16'h0, e});
        wr(8'h00, 8'h05);
        wr(8'h3C, 8'h05);
        wr(8'h1C, 8'h00);
        for (int j = 0; j < 5; j++)
        begin
            slow <= j[0];
            tx <= pat[j];
            fchk(8'h05, pat[j][15] | pat[j][0]);
        end
        tx <= 16'h0080;
        fchk(8'h27, 1'b0);
        fchk(8'h00, 1'b0);
        slow <= 0;
        wr(8'h04, IL);
        wr(8'h80, IL);
        for (int j = 0; j < 4; j++)
        begin
            tx <= {14'h0, j[0], 1'b0};
            din <= {5'h0, j[1]};
            fchk(IL, j == 3);
            rchk(8'hC8, {31'h0, j == 3});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
